// >>> qsm_mapper.v
`timescale 1ns/1ps
`default_nettype none
`include "qsm_regs.vh"

// Functional notes
// - four channels share stage enables
// - per-channel gain and tuning settings
// - 8-bit word in, 5-bit I/Q out
// - seven constellations, 16 to 256 points
// - select is 3-bit field, bits 2:0
// - select decode; code 111 unused
// - only low bits of selected size used
// - coordinates within per-mode magnitude limits
// - coordinates are 5-bit two's complement
// - B64 all-ones maps to upper-right corner
// - B64 011101 gives I=6, Q=-10
// - scaling only while mapper bypassed
// - shaping-first bypass takes top five bits
module qsm_mapper #(
	parameter CH = `QSM_CHANNELS
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_b,
	// shared configuration
	input wire [`QSM_SEL_W-1:0] constellation_select,
	input wire mapper_enable,
	input wire pulse_shaping_filter_enable,
	// per-channel configuration
	input wire [CH*`QSM_GAIN_W-1:0] input_gain_factor,
	input wire [CH*`QSM_TUNE_W-1:0] freq_tune_word,
	// host data words
	input wire [CH*`QSM_WORD_W-1:0] in_word,
	input wire [CH-1:0] in_valid,
	output wire [CH-1:0] in_ready,
	// samples to the interpolation chain
	output wire [CH*`QSM_COORD_W-1:0] sym_i,
	output wire [CH*`QSM_COORD_W-1:0] sym_q,
	output wire [CH*`QSM_WORD_W-1:0] raw_word,
	output wire [CH-1:0] out_valid,
	input wire [CH-1:0] out_ready,
	// settings for the downstream stages
	output reg scale_active,
	output reg [CH*`QSM_GAIN_W-1:0] gain_out,
	output reg [CH*`QSM_TUNE_W-1:0] tune_out,
	output reg select_invalid
);

	localparam BW = `QSM_WORD_W + 2 * `QSM_COORD_W;

	// index * step - offset, wrapped to five bits
	function [4:0] qsm_lvl;
		input [3:0] idx;
		input [4:0] step;
		input [4:0] off;
		reg [7:0] t;
		begin
			t = {4'h0, idx} * {3'h0, step} - {3'h0, off};
			qsm_lvl = t[4:0];
		end
	endfunction

	function [4:0] qsm_neg;
		input [4:0] x;
		begin
			qsm_neg = (~x) + 5'h01;
		end
	endfunction

	// returns {i, q}
	function [9:0] qsm_map;
		input [2:0] sel;
		input [7:0] d;
		reg [4:0] i;
		reg [4:0] q;
		reg [4:0] along;
		reg [4:0] arm_lvl;
		begin
			i = 5'h00;
			q = 5'h00;
			along = 5'h00;
			arm_lvl = 5'h00;
			case (sel)
				`QSM_B64: begin
					// xnor-coupled Q index: corner at all ones, 64 distinct points
					i = qsm_lvl({1'b0, d[2:0]}, `QSM_STEP_64, `QSM_OFF_64);
					q = qsm_lvl({1'b0, d[5], ~(d[5] ^ d[4]), d[3]},
						`QSM_STEP_64, `QSM_OFF_64);
				end
				`QSM_B256: begin
					i = qsm_lvl(d[7:4], `QSM_STEP_256, `QSM_OFF_256);
					q = qsm_lvl(d[3:0], `QSM_STEP_256, `QSM_OFF_256);
				end
				`QSM_A16: begin
					i = qsm_lvl({2'h0, d[1:0]}, `QSM_STEP_16, `QSM_OFF_16);
					q = qsm_lvl({2'h0, d[3:2]}, `QSM_STEP_16, `QSM_OFF_16);
				end
				`QSM_A32: begin
					// 4x4 core plus four one-wide arms at the full-scale edge
					along = qsm_lvl({2'h0, d[1:0]}, `QSM_STEP_32, `QSM_OFF_32);
					if (!d[4]) begin
						i = along;
						q = qsm_lvl({2'h0, d[3:2]}, `QSM_STEP_32, `QSM_OFF_32);
					end else begin
						case (d[3:2])
							2'h0: begin
								i = `QSM_EDGE_32;
								q = along;
							end
							2'h1: begin
								i = qsm_neg(`QSM_EDGE_32);
								q = along;
							end
							2'h2: begin
								i = along;
								q = `QSM_EDGE_32;
							end
							default: begin
								i = along;
								q = qsm_neg(`QSM_EDGE_32);
							end
						endcase
					end
				end
				`QSM_AC64: begin
					i = qsm_lvl({1'b0, d[2:0]}, `QSM_STEP_64, `QSM_OFF_64);
					q = qsm_lvl({1'b0, d[5:3]}, `QSM_STEP_64, `QSM_OFF_64);
				end
				`QSM_AC128: begin
					// 8x8 core plus four two-wide arms, limit eleven
					along = qsm_lvl({1'b0, d[2:0]}, `QSM_STEP_128, `QSM_OFF_128);
					arm_lvl = d[3] ? `QSM_EDGE_128_OUT : `QSM_EDGE_128_IN;
					if (!d[6]) begin
						i = along;
						q = qsm_lvl({1'b0, d[5:3]}, `QSM_STEP_128, `QSM_OFF_128);
					end else begin
						case (d[5:4])
							2'h0: begin
								i = arm_lvl;
								q = along;
							end
							2'h1: begin
								i = qsm_neg(arm_lvl);
								q = along;
							end
							2'h2: begin
								i = along;
								q = arm_lvl;
							end
							default: begin
								i = along;
								q = qsm_neg(arm_lvl);
							end
						endcase
					end
				end
				`QSM_AC256: begin
					i = qsm_lvl(d[3:0], `QSM_STEP_256, `QSM_OFF_256);
					q = qsm_lvl(d[7:4], `QSM_STEP_256, `QSM_OFF_256);
				end
				default: begin
					i = 5'h00;
					q = 5'h00;
				end
			endcase
			qsm_map = {i, q};
		end
	endfunction

	// shared stage state, sampled once for all channels
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			scale_active <= 1'b0;
			select_invalid <= 1'b0;
			gain_out <= {CH{`QSM_GAIN_RESET}};
			tune_out <= {CH{`QSM_TUNE_RESET}};
		end else begin
			scale_active <= ~mapper_enable;
			select_invalid <= mapper_enable &
				(constellation_select == `QSM_UNUSED);
			gain_out <= input_gain_factor;
			tune_out <= freq_tune_word;
		end
	end

	genvar c;
	generate
		for (c = 0; c < CH; c = c + 1) begin : g_ch
			wire [`QSM_WORD_W-1:0] word;
			wire [9:0] mapped;
			reg [`QSM_COORD_W-1:0] pre_i;
			reg [`QSM_COORD_W-1:0] pre_q;
			wire [BW-1:0] buf_out;

			assign word = in_word[c*`QSM_WORD_W +: `QSM_WORD_W];
			assign mapped = qsm_map(constellation_select, word);

			always @* begin
				if (mapper_enable) begin
					pre_i = mapped[9:5];
					pre_q = mapped[4:0];
				end else if (pulse_shaping_filter_enable) begin
					pre_i = word[7:3];
					pre_q = 5'h00;
				end else begin
					pre_i = 5'h00;
					pre_q = 5'h00;
				end
			end

			// one two-entry buffer per channel, same for all
			qsm_buf2 #(
				.W(BW)
			) u_buf (
				.clk_sys(clk_sys),
				.rst_b(rst_b),
				.in_data({word, pre_i, pre_q}),
				.in_valid(in_valid[c]),
				.in_ready(in_ready[c]),
				.out_data(buf_out),
				.out_valid(out_valid[c]),
				.out_ready(out_ready[c])
			);

			assign raw_word[c*`QSM_WORD_W +: `QSM_WORD_W] = buf_out[BW-1 -: `QSM_WORD_W];
			assign sym_i[c*`QSM_COORD_W +: `QSM_COORD_W] = buf_out[9:5];
			assign sym_q[c*`QSM_COORD_W +: `QSM_COORD_W] = buf_out[4:0];
		end
	endgenerate

endmodule // qsm_mapper

`default_nettype wire

// >>> qsm_regs.vh
`ifndef QSM_REGS_VH
`define QSM_REGS_VH

// channel count and widths
`define QSM_CHANNELS 4
`define QSM_WORD_W 8
`define QSM_COORD_W 5
`define QSM_GAIN_W 8
`define QSM_TUNE_W 24
`define QSM_SEL_W 3

// constellation_select codes (bits 2:0 of mapper_shaping_config)
`define QSM_B64 3'h0
`define QSM_B256 3'h1
`define QSM_A16 3'h2
`define QSM_A32 3'h3
`define QSM_AC64 3'h4
`define QSM_AC128 3'h5
`define QSM_AC256 3'h6
`define QSM_UNUSED 3'h7

// level = index * step - offset
`define QSM_STEP_16 5'h0A
`define QSM_OFF_16 5'h0F
`define QSM_STEP_32 5'h06
`define QSM_OFF_32 5'h09
`define QSM_STEP_64 5'h04
`define QSM_OFF_64 5'h0E
`define QSM_STEP_128 5'h02
`define QSM_OFF_128 5'h07
`define QSM_STEP_256 5'h02
`define QSM_OFF_256 5'h0F

// outer levels of the cross constellations
`define QSM_EDGE_32 5'h0F
`define QSM_EDGE_128_IN 5'h09
`define QSM_EDGE_128_OUT 5'h0B

// reset values
`define QSM_GAIN_RESET 8'h20
`define QSM_TUNE_RESET 24'h00_0000

`endif

// >>> qsm_buf2.v
`timescale 1ns/1ps
`default_nettype none

module qsm_buf2 #(
	parameter W = 18
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_b,
	// filling side
	input wire [W-1:0] in_data,
	input wire in_valid,
	output reg in_ready,
	// draining side
	output reg [W-1:0] out_data,
	output reg out_valid,
	input wire out_ready
);

	reg [W-1:0] slot1;
	reg [1:0] count;
	reg [1:0] next_count;
	wire push;
	wire pop;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @* begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 2'h1;
		end else if (pop && !push) begin
			next_count = count - 2'h1;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			count <= 2'h0;
			out_valid <= 1'b0;
			in_ready <= 1'b0;
			out_data <= {W{1'b0}};
			slot1 <= {W{1'b0}};
		end else begin
			count <= next_count;
			out_valid <= (next_count != 2'h0);
			in_ready <= (next_count != 2'h2);
			if (push && !pop) begin
				if (count == 2'h0) begin
					out_data <= in_data;
				end else begin
					slot1 <= in_data;
				end
			end else if (pop && !push) begin
				out_data <= slot1;
			end else if (push && pop) begin
				if (count == 2'h1) begin
					out_data <= in_data;
				end else begin
					out_data <= slot1;
					slot1 <= in_data;
				end
			end
		end
	end

endmodule // qsm_buf2

`default_nettype wire

// >>> qsm_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module qsm_chk (
	// watched ports
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [2:0] constellation_select,
	input wire logic mapper_enable,
	input wire logic [31:0] input_gain_factor,
	input wire logic [31:0] in_word,
	input wire logic [3:0] in_valid,
	input wire logic [3:0] in_ready,
	input wire logic [19:0] sym_i,
	input wire logic [19:0] sym_q,
	input wire logic [3:0] out_valid,
	input wire logic [3:0] out_ready,
	input wire logic scale_active,
	input wire logic [31:0] gain_out,
	input wire logic select_invalid
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// channel 0 word taken into an empty buffer
	wire logic take = in_valid[0] && in_ready[0] && !out_valid[0];
	wire logic b64 = take && mapper_enable && constellation_select == 3'h0;
	fill_a: assert property (in_valid[0] && in_ready[0] |=> out_valid[0])
		else $error("sample missing");
	hold_a: assert property (out_valid[0] && !out_ready[0] |=> out_valid[0] && $stable(sym_i[4:0]))
		else $error("stalled sample moved");
	full_a: assert property ((in_valid[0] && in_ready[0] && !out_ready[0]) [*2] |=> !in_ready[0])
		else $error("ready with full buffer");
	corner_a: assert property (b64 && in_word[5:0] == 6'h3f |=> sym_i[4:0] == 5'h0e && sym_q[4:0] == 5'h0e)
		else $error("corner point wrong");
	pair_a: assert property (b64 && in_word[5:0] == 6'h1d |=> sym_i[4:0] == 5'h06 && sym_q[4:0] == 5'h16)
		else $error("pair point wrong");
	scale_a: assert property (1'b1 |=> scale_active == !$past(mapper_enable))
		else $error("scale flag wrong");
	invalid_a: assert property (mapper_enable && constellation_select == 3'h7 |=> select_invalid)
		else $error("unused code not flagged");
	gain_a: assert property (1'b1 |=> gain_out == $past(input_gain_factor))
		else $error("gain copy wrong");
endmodule // qsm_chk
`default_nettype wire

// >>> qsm_host.sv
`timescale 1ns/1ps
`default_nettype none
module qsm_host (
	// clock
	input wire logic clk_sys,
	// word handshake
	output var logic [7:0] word,
	output var logic valid,
	input wire logic ready
);
	initial begin
		word = 8'h00;
		valid = 1'b0;
	end
	// word held until ready seen at an edge; released word is inverted
	task send(input logic [7:0] w, input logic last);
		word <= w;
		valid <= 1'b1;
		@(posedge clk_sys);
		while (!ready) @(posedge clk_sys);
		if (last) begin
			valid <= 1'b0;
			word <= ~w;
		end
	endtask
endmodule // qsm_host
`default_nettype wire

// >>> tb_qsm_mapper.sv
`timescale 1ns/1ps
`default_nettype none
module tb_qsm_mapper;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] constellation_select = 3'h0;
	logic mapper_enable = 1'b1;
	logic pulse_shaping_filter_enable = 1'b0;
	logic [31:0] input_gain_factor = 32'h2020_2020;
	logic [3:0] out_ready = 4'h0;
	logic [95:0] freq_tune_word = 96'h0;
	wire [31:0] in_word;
	wire [3:0] in_valid;
	wire [3:0] in_ready;
	wire [19:0] sym_i;
	wire [19:0] sym_q;
	wire [3:0] out_valid;
	wire [31:0] gain_out;
	wire scale_active;
	wire select_invalid;
	wire [31:0] raw_word;
	wire [95:0] tune_out;
	int error_cnt = 0;
	int num_checks = 0;
	logic [4:0] lvl [7] = '{5'h12, 5'h11, 5'h11, 5'h17, 5'h12, 5'h19, 5'h11};
	logic [7:0] wd [7] = '{8'hd0, 8'h00, 8'hf0, 8'he0, 8'hc0, 8'h80, 8'h00};
	// second word per mode: distinct I and Q, arms of the cross constellations
	logic [7:0] wd2 [7] = '{8'hc5, 8'hf0, 8'h5e, 8'hf7, 8'hfa, 8'hf8, 8'h0f};
	logic [4:0] li2 [7] = '{5'h06, 5'h0f, 5'h05, 5'h11, 5'h1a, 5'h19, 5'h0f};
	logic [4:0] lq2 [7] = '{5'h1a, 5'h11, 5'h0f, 5'h09, 5'h0e, 5'h15, 5'h11};
	initial forever #4 clk_sys = ~clk_sys;
	for (genvar g = 0; g < 4; g++) begin : host_g
		qsm_host qsm_host_i (.clk_sys, .word(in_word[8*g+:8]), .valid(in_valid[g]),
			.ready(in_ready[g]));
	end
	qsm_mapper qsm_mapper_i (.clk_sys, .rst_b, .constellation_select, .mapper_enable,
		.pulse_shaping_filter_enable, .input_gain_factor, .freq_tune_word, .in_word,
		.in_valid, .in_ready, .sym_i, .sym_q, .raw_word, .out_valid, .out_ready,
		.scale_active, .gain_out, .tune_out, .select_invalid);
	task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task recv(input int c, input logic [4:0] ei, input logic [4:0] eq, input logic [7:0] er);
		int n;
		n = 0;
		out_ready[c] <= 1'b1;
		@(negedge clk_sys);
		while (!out_valid[c] && n < 40) begin
			n++;
			@(negedge clk_sys);
		end
		chk("out_valid", {7'h0, out_valid[c]}, 8'h01);
		chk("sym_i", sym_i[5*c+:5], ei);
		chk("sym_q", sym_q[5*c+:5], eq);
		chk("raw_word", raw_word[8*c+:8], er);
		@(posedge clk_sys);
	endtask
	task t_walk;
		@(posedge clk_sys);
		host_g[0].qsm_host_i.send(8'hdd, 1'b0);
		host_g[0].qsm_host_i.send(8'h00, 1'b1);
		@(negedge clk_sys);
		chk("in_ready", {7'h0, in_ready[0]}, 8'h00);
		@(posedge clk_sys);
		recv(0, 5'h06, 5'h16, 8'hdd);
		recv(0, 5'h12, 5'h1a, 8'h00);
		$display("walk end");
	endtask
	task t_modes;
		for (int k = 0; k < 7; k++) begin
			constellation_select <= k[2:0];
			host_g[3].qsm_host_i.send(wd[k], 1'b1);
			recv(3, lvl[k], lvl[k], wd[k]);
			host_g[3].qsm_host_i.send(wd2[k], 1'b1);
			recv(3, li2[k], lq2[k], wd2[k]);
		end
		$display("modes end");
	endtask
	task t_other;
		constellation_select <= 3'h0;
		input_gain_factor <= 32'h0102_0304;
		freq_tune_word <= 96'h3333_3322_2222_1111_110a_0b0c;
		host_g[0].qsm_host_i.send(8'hff, 1'b1);
		recv(0, 5'h0e, 5'h0e, 8'hff);
		chk("gain_out", gain_out[7:0], 8'h04);
		chk("gain_out", gain_out[31:24], 8'h01);
		chk("tune_out", tune_out[7:0], 8'h0c);
		chk("tune_out", tune_out[95:88], 8'h33);
		constellation_select <= 3'h7;
		host_g[0].qsm_host_i.send(8'h5a, 1'b1);
		recv(0, 5'h00, 5'h00, 8'h5a);
		chk("select_invalid", {7'h0, select_invalid}, 8'h01);
		mapper_enable <= 1'b0;
		pulse_shaping_filter_enable <= 1'b1;
		host_g[0].qsm_host_i.send(8'ha5, 1'b1);
		recv(0, 5'h14, 5'h00, 8'ha5);
		chk("scale_active", {7'h0, scale_active}, 8'h01);
		$display("other end");
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_walk;
		t_modes;
		t_other;
		give_verdict;
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		error_cnt++;
		give_verdict;
	end
endmodule // tb_qsm_mapper
bind qsm_mapper qsm_chk qsm_chk_i (.clk_sys, .rst_b, .constellation_select, .mapper_enable,
	.input_gain_factor, .in_word, .in_valid, .in_ready, .sym_i, .sym_q, .out_valid,
	.out_ready, .scale_active, .gain_out, .select_invalid);
`default_nettype wire
